// ### rtl/smcg_pkg.sv
/*
 * Package for the sleep-mode clock-gating controller: mode codes,
 * gate vector layout, state encoding and reset values.
 * Assumes a single 200 MHz reference clock.
 */
package smcg_pkg;

    // sleep mode select codes
    typedef enum logic [2:0] {
        SMCG_MODE_IDLE     = 3'h0,
        SMCG_MODE_ADC_QUIET = 3'h1,
        SMCG_MODE_PWR_DOWN = 3'h2,
        SMCG_MODE_PWR_SAVE = 3'h3,
        SMCG_MODE_STANDBY  = 3'h6,
        SMCG_MODE_EXT_STBY = 3'h7
    } smcg_mode_e;

    // per-domain clock enables
    typedef struct packed {
        logic cpu;
        logic sram;
        logic timer;
        logic spi;
        logic irq;
        logic adc;
        logic async_tmr;
        logic osc;
    } smcg_gate_s;

    localparam smcg_gate_s SMCG_ALL_ON = 8'hff;

    typedef enum logic [1:0] {
        SMCG_RUN,
        SMCG_SLEEP,
        SMCG_WAKE
    } smcg_state_e;

    // cycles of gate restore before the core is released
    localparam int unsigned SMCG_WAKE_CYCLES = 2;
    localparam logic [1:0]  SMCG_WAKE_CNT_W1 = 2'(SMCG_WAKE_CYCLES - 1);

    typedef struct packed {
        smcg_state_e state;
        smcg_gate_s  gate;
        logic [1:0]  wake_cnt;
        logic        bad_mode;
    } smcg_state_s;

    localparam smcg_state_s SMCG_RESET_STATE =
        '{state: SMCG_RUN, gate: SMCG_ALL_ON, wake_cnt: 2'h0,
          bad_mode: 1'b0};

endpackage

// ### rtl/smcg_ctrl.sv
/*
 * Sleep-mode clock-gating controller. Gates domain clocks per selected
 * sleep mode; on wake restores all but the cpu clock before releasing the core.
 * Assumes the core raises sleep_req for one cycle on a sleep instruction
 * with sleep_en set, and waits for core_run before executing again.
 */
// Functional notes
// - six software-selectable sleep modes
// - idle: only processor clock halted
// - power-down: oscillator stopped, wake by interrupt/reset
// - power-save: as power-down, async timer runs
// - adc quiet: only oscillator, async timer and ADC clocked
// - standby: oscillator runs, all else sleeps
// - extended standby: oscillator and async timer run
`timescale 1ns/1ps
`default_nettype none

module smcg_ctrl (
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               sys_rst,
    // core side
    input  wire logic               sleep_en,
    input  wire logic [2:0]         sleep_mode,
    input  wire logic               sleep_req,
    input  wire logic               wake_irq,
    output logic                    core_run,
    output logic                    mode_illegal,
    // gated domains
    output smcg_pkg::smcg_gate_s    clk_gate
);

    smcg_pkg::smcg_state_s st;
    smcg_pkg::smcg_state_s next_st;

    function automatic smcg_pkg::smcg_gate_s mode_gates(
        input logic [2:0] m);
        smcg_pkg::smcg_gate_s g;
        g = '0;
        unique case (m)
            smcg_pkg::SMCG_MODE_IDLE: begin
                g = smcg_pkg::SMCG_ALL_ON;
                g.cpu = 1'b0;
            end
            smcg_pkg::SMCG_MODE_ADC_QUIET: begin
                g.adc = 1'b1;
                g.async_tmr = 1'b1;
                g.osc = 1'b1;
            end
            smcg_pkg::SMCG_MODE_PWR_DOWN: begin
                g = '0;
            end
            smcg_pkg::SMCG_MODE_PWR_SAVE: begin
                g.async_tmr = 1'b1;
            end
            smcg_pkg::SMCG_MODE_STANDBY: begin
                g.osc = 1'b1;
            end
            smcg_pkg::SMCG_MODE_EXT_STBY: begin
                g.osc = 1'b1;
                g.async_tmr = 1'b1;
            end
            default: begin
                g = smcg_pkg::SMCG_ALL_ON;
            end
        endcase
        return g;
    endfunction

    function automatic logic mode_ok(input logic [2:0] m);
        return (m == smcg_pkg::SMCG_MODE_IDLE) ||
               (m == smcg_pkg::SMCG_MODE_ADC_QUIET) ||
               (m == smcg_pkg::SMCG_MODE_PWR_DOWN) ||
               (m == smcg_pkg::SMCG_MODE_PWR_SAVE) ||
               (m == smcg_pkg::SMCG_MODE_STANDBY) ||
               (m == smcg_pkg::SMCG_MODE_EXT_STBY);
    endfunction

    always_comb begin
        next_st = st;
        unique case (st.state)
            smcg_pkg::SMCG_RUN: begin
                next_st.gate = smcg_pkg::SMCG_ALL_ON;
                if (sleep_req && sleep_en) begin
                    // reserved codes do not sleep, flag them
                    if (mode_ok(sleep_mode)) begin
                        next_st.state = smcg_pkg::SMCG_SLEEP;
                        next_st.gate = mode_gates(sleep_mode);
                        next_st.bad_mode = 1'b0;
                    end else begin
                        next_st.bad_mode = 1'b1;
                    end
                end
            end
            smcg_pkg::SMCG_SLEEP: begin
                if (wake_irq) begin
                    next_st.state = smcg_pkg::SMCG_WAKE;
                    next_st.gate = smcg_pkg::SMCG_ALL_ON;
                    next_st.gate.cpu = 1'b0;
                    next_st.wake_cnt = smcg_pkg::SMCG_WAKE_CNT_W1;
                end
            end
            smcg_pkg::SMCG_WAKE: begin
                if (st.wake_cnt == 2'h0) begin
                    next_st.state = smcg_pkg::SMCG_RUN;
                    next_st.gate = smcg_pkg::SMCG_ALL_ON;
                end else begin
                    next_st.wake_cnt = st.wake_cnt - 2'h1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= smcg_pkg::SMCG_RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    assign clk_gate = st.gate;
    assign core_run = (st.state == smcg_pkg::SMCG_RUN);
    assign mode_illegal = st.bad_mode;

endmodule

`default_nettype wire

// ### tb/smcg_core_model.sv
/* core model: one-cycle sleep request per go, only while core_run.
   assumes go, mode and en change at the falling edge */
`timescale 1ns/1ps
`default_nettype none
module smcg_core_model (
    input  wire logic       ref_clk,
    input  wire logic       go,
    input  wire logic [2:0] mode,
    input  wire logic       en,
    input  wire logic       core_run,
    output var logic        sleep_req,
    output var logic [2:0]  sleep_mode,
    output var logic        sleep_en
);
    initial {sleep_req, sleep_mode, sleep_en} = '0;
    always @(negedge ref_clk) begin
        sleep_req <= go && core_run;
        sleep_mode <= mode;
        sleep_en <= en;
    end
endmodule
`default_nettype wire

// ### tb/smcg_ctrl_monitor.sv
/* assertions on smcg_ctrl ports; bound below */
`timescale 1ns/1ps
`default_nettype none
module smcg_ctrl_monitor (
    input wire logic                 ref_clk,
    input wire logic                 sys_rst,
    input wire logic                 sleep_en,
    input wire logic [2:0]           sleep_mode,
    input wire logic                 sleep_req,
    input wire logic                 wake_irq,
    input wire logic                 core_run,
    input wire logic                 mode_illegal,
    input wire smcg_pkg::smcg_gate_s clk_gate
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence s_take(logic [2:0] m);
        core_run && sleep_req && sleep_en && sleep_mode == m;
    endsequence
    sequence s_restore;
        (clk_gate == 8'h7f && !core_run) [*2] ##1
            (core_run && clk_gate == 8'hff);
    endsequence
    property p_gate(logic [2:0] m, logic [7:0] g);
        s_take(m) |=> clk_gate == g && !core_run;
    endproperty
    a_idle_gates: assert property (p_gate(3'h0, 8'h7f))
        else $error("idle");
    a_pdown_gates: assert property (p_gate(3'h2, 8'h00))
        else $error("power down");
    a_psave_gates: assert property (p_gate(3'h3, 8'h02))
        else $error("power save");
    a_quiet_gates: assert property (p_gate(3'h1, 8'h07))
        else $error("adc quiet");
    a_stby_gates: assert property (p_gate(3'h6, 8'h01))
        else $error("standby");
    a_xstby_gates: assert property (p_gate(3'h7, 8'h03))
        else $error("ext standby");
    a_wake_restore: assert property (wake_irq && !core_run
        && !$past(wake_irq) |=> s_restore) else $error("wake");
    a_bad_mode: assert property (s_take(3'h4) |=> mode_illegal
        && core_run && clk_gate == 8'hff) else $error("reserved");
endmodule
bind smcg_ctrl smcg_ctrl_monitor u_mon (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .sleep_en(sleep_en), .sleep_mode(sleep_mode),
    .sleep_req(sleep_req), .wake_irq(wake_irq), .core_run(core_run),
    .mode_illegal(mode_illegal), .clk_gate(clk_gate));
`default_nettype wire

// ### tb/smcg_ctrl_tb.sv
/* bench for smcg_ctrl; smcg_core_model issues the sleep requests */
`timescale 1ns/1ps
`default_nettype none
module smcg_ctrl_tb;
    logic ref_clk = 0, sys_rst = 1, go = 0, en = 1, wake_irq = 0;
    logic [2:0] mode = '0, sleep_mode;
    logic sleep_en, sleep_req, core_run, mode_illegal;
    smcg_pkg::smcg_gate_s clk_gate;
    int miscompares = 0, samples_checked = 0, cyc = 0;
    logic [10:0] rows [6] = '{11'h07f, 11'h107, 11'h200, 11'h302,
                              11'h601, 11'h703};
    always #2.5 ref_clk = ~ref_clk;
    smcg_core_model core (.ref_clk(ref_clk), .go(go), .mode(mode),
        .en(en), .core_run(core_run), .sleep_req(sleep_req),
        .sleep_mode(sleep_mode), .sleep_en(sleep_en));
    smcg_ctrl dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .sleep_en(sleep_en), .sleep_mode(sleep_mode),
        .sleep_req(sleep_req), .wake_irq(wake_irq), .core_run(core_run),
        .mode_illegal(mode_illegal), .clk_gate(clk_gate));
    task chk(input logic [9:0] e);
        samples_checked++;
        if ({mode_illegal, core_run, clk_gate} !== e) begin
            miscompares++;
            $display("unexpected %0t exp %h", $time, e);
        end
    endtask
    task issue(input logic [2:0] m);
        @(negedge ref_clk);
        go <= 1;
        mode <= m;
        @(negedge ref_clk);
        go <= 0;
        @(negedge ref_clk);
    endtask
    task close_out;
        $display("miscompares %0d checked %0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge ref_clk) if (++cyc == 3000) begin
        miscompares++;
        close_out;
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 0;
        chk(10'h1ff);
        foreach (rows[i]) begin
            issue(rows[i][10:8]);
            chk({2'b00, rows[i][7:0]});
            wake_irq <= 1;
            @(negedge ref_clk);
            wake_irq <= 0;
            chk(10'h07f);
            repeat (2) @(negedge ref_clk);
            chk(10'h1ff);
        end
        issue(3'h4);
        chk(10'h3ff);
        issue(3'h5);
        chk(10'h3ff);
        en <= 0;
        issue(3'h2);
        chk(10'h3ff);
        en <= 1;
        issue(3'h2);
        chk(10'h000);
        sys_rst <= 1;
        @(negedge ref_clk);
        chk(10'h1ff);
        close_out;
    end
endmodule
`default_nettype wire
